// File: rtl/eia_aggregator.sv
/*
 Event interrupt aggregator: per-chip, per-link and per-lane event groups
 combined onto one open-drain, active-low alert output.
 Assumes a register access port from the configuration-port core on clk_in,
 and event triggers from device logic on the same clock.
*/
`include "eia_consts.svh"

// Contract
// - Alert pin is open-drain, active low, pulled up outside, wire-OR capable.
// - Unarmed event keeps its latched flag at zero.
// - Armed event's trigger rising edge sets its sticky flag.
// - Alert pulled low while any flag is set, released otherwise.
// - Flag clears by its clear strobe or by device reset.
// - Status readback returns raw trigger or latched flag by selection.
// - Several register groups together monitor up to 75 events.
// - Per-chip readback: flag when armed, raw trigger when not.
// - Link and lane readback: flag when armed, zero when not.
// - Per-chip arm register read/write; status register reads status, writes clear.
// - Lane group arm by two writes; two status registers read and clear.
// - Link registers take arm writes, clear writes, and return status.
// - Datapath I and Q check failures are per-chip events, bits 1:0.
module eia_aggregator (
	input  wire logic                         clk_in,
	input  wire logic                         reset_n_in,
	input  wire logic                         wr_en_in,
	input  wire logic                         rd_en_in,
	input  wire eia_pkg::eia_addr_t           addr_in,
	input  wire eia_pkg::eia_data_t           wr_data_in,
	input  wire logic [`EIA_CHIP_EVENTS-1:0]  chip_trig_in,
	input  wire logic [`EIA_LINK_EVENTS-1:0]  link_trig_in,
	input  wire logic [`EIA_LANE_EVENTS-1:0]  lane_trig_in,
	output eia_pkg::eia_data_t                rd_data_out,
	output logic                              rd_valid_out,
	output logic                              alert_n_out,
	output logic                              alert_oe_n_out
);
	// ======================================================================
	// Arm registers
	logic [`EIA_CHIP_EVENTS-1:0] chip_arm_ff;
	logic [`EIA_LINK_EVENTS-1:0] link_arm_ff;
	logic [`EIA_LANE_EVENTS-1:0] lane_arm_ff;
	logic [`EIA_CHIP_EVENTS-1:0] chip_clr;
	logic [`EIA_LINK_EVENTS-1:0] link_clr;
	logic [`EIA_LANE_EVENTS-1:0] lane_clr;
	logic [`EIA_CHIP_EVENTS-1:0] chip_flag;
	logic [`EIA_LINK_EVENTS-1:0] link_flag;
	logic [`EIA_LANE_EVENTS-1:0] lane_flag;
	logic [`EIA_CHIP_EVENTS-1:0] chip_rdbk;
	logic [`EIA_LINK_EVENTS-1:0] link_rdbk;
	logic [`EIA_LANE_EVENTS-1:0] lane_rdbk;
	eia_pkg::eia_data_t          nxt_rd_data;
	logic                        any_flag;
	eia_pkg::eia_data_t          rd_data_ff;
	logic                        rd_valid_ff;
	logic                        alert_oe_n_ff;
	logic                        alert_n_ff;

	// Per-chip arm word, readable and writable
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			chip_arm_ff <= `EIA_CHIP_ARM_RST;
		end else if (wr_en_in && addr_in == `EIA_CHIP_ARM_ADDR) begin
			chip_arm_ff <= wr_data_in;
		end
	end

	// Link group arm words, low byte then high byte
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			link_arm_ff <= `EIA_GRP_ARM_RST;
		end else if (wr_en_in && addr_in == `EIA_LINK_ARM0_ADDR) begin
			link_arm_ff[7:0] <= wr_data_in;
		end else if (wr_en_in && addr_in == `EIA_LINK_ARM1_ADDR) begin
			link_arm_ff[15:8] <= wr_data_in;
		end
	end

	// Lane group arm words are write only; reads return zero
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			lane_arm_ff <= `EIA_GRP_ARM_RST;
		end else if (wr_en_in && addr_in == `EIA_LANE_ARM0_ADDR) begin
			lane_arm_ff[7:0] <= wr_data_in;
		end else if (wr_en_in && addr_in == `EIA_LANE_ARM1_ADDR) begin
			lane_arm_ff[15:8] <= wr_data_in;
		end
	end

	// ======================================================================
	// Write-one-to-clear strobes, one cycle wide with the write
	always_comb begin
		chip_clr = '0;
		link_clr = '0;
		lane_clr = '0;
		if (wr_en_in) begin
			case (addr_in)
				`EIA_CHIP_STAT_ADDR:  chip_clr = wr_data_in;
				`EIA_LINK_STAT0_ADDR: link_clr[7:0] = wr_data_in;
				`EIA_LINK_STAT1_ADDR: link_clr[15:8] = wr_data_in;
				`EIA_LANE_STAT0_ADDR: lane_clr[7:0] = wr_data_in;
				`EIA_LANE_STAT1_ADDR: lane_clr[15:8] = wr_data_in;
				default:              chip_clr = '0;
			endcase
		end
	end

	// ======================================================================
	// Event groups: 8 + 16 + 16 events, within the 75 the scheme allows
	// Per-chip readback selection follows the arm bit
	eia_event_cell #(.W(`EIA_CHIP_EVENTS)) u_chip (
		.clk_in      (clk_in),
		.reset_n_in  (reset_n_in),
		.trig_in     (chip_trig_in),
		.arm_in      (chip_arm_ff),
		.clr_in      (chip_clr),
		.sel_flag_in (chip_arm_ff),
		.flag_out    (chip_flag),
		.rdbk_out    (chip_rdbk)
	);

	// Link and lane readback always selects the flag, zero when unarmed
	eia_event_cell #(.W(`EIA_LINK_EVENTS)) u_link (
		.clk_in      (clk_in),
		.reset_n_in  (reset_n_in),
		.trig_in     (link_trig_in),
		.arm_in      (link_arm_ff),
		.clr_in      (link_clr),
		.sel_flag_in ({`EIA_LINK_EVENTS{1'b1}}),
		.flag_out    (link_flag),
		.rdbk_out    (link_rdbk)
	);

	eia_event_cell #(.W(`EIA_LANE_EVENTS)) u_lane (
		.clk_in      (clk_in),
		.reset_n_in  (reset_n_in),
		.trig_in     (lane_trig_in),
		.arm_in      (lane_arm_ff),
		.clr_in      (lane_clr),
		.sel_flag_in ({`EIA_LANE_EVENTS{1'b1}}),
		.flag_out    (lane_flag),
		.rdbk_out    (lane_rdbk)
	);

	// ======================================================================
	// Read mux; unmapped and write-only addresses read as zero
	always_comb begin
		nxt_rd_data = `EIA_RD_DATA_RST;
		case (addr_in)
			`EIA_CHIP_ARM_ADDR:   nxt_rd_data = chip_arm_ff;
			`EIA_CHIP_STAT_ADDR:  nxt_rd_data = chip_rdbk;
			`EIA_LINK_ARM0_ADDR:  nxt_rd_data = link_rdbk[7:0];
			`EIA_LINK_ARM1_ADDR:  nxt_rd_data = link_rdbk[15:8];
			`EIA_LINK_STAT0_ADDR: nxt_rd_data = link_rdbk[7:0];
			`EIA_LINK_STAT1_ADDR: nxt_rd_data = link_rdbk[15:8];
			`EIA_LANE_STAT0_ADDR: nxt_rd_data = lane_rdbk[7:0];
			`EIA_LANE_STAT1_ADDR: nxt_rd_data = lane_rdbk[15:8];
			default:              nxt_rd_data = `EIA_RD_DATA_RST;
		endcase
	end

	// Read data registered: one cycle after the read strobe
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rd_data_ff  <= `EIA_RD_DATA_RST;
			rd_valid_ff <= 1'b0;
		end else begin
			rd_valid_ff <= rd_en_in;
			if (rd_en_in) begin
				rd_data_ff <= nxt_rd_data;
			end
		end
	end

	// ======================================================================
	// Open-drain alert: data pin held low, enable low while any flag is set.
	// Driving only a low level keeps the pin safe to wire-OR with others.
	assign any_flag = (|chip_flag) | (|link_flag) | (|lane_flag);

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			alert_n_ff    <= 1'b0;
			alert_oe_n_ff <= 1'b1;
		end else begin
			alert_n_ff    <= 1'b0;
			alert_oe_n_ff <= ~any_flag;
		end
	end

	assign rd_data_out    = rd_data_ff;
	assign rd_valid_out   = rd_valid_ff;
	assign alert_n_out    = alert_n_ff;
	assign alert_oe_n_out = alert_oe_n_ff;

	// ======================================================================
	// Assertions
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!reset_n_in);

	// Armed rising edge on event 0 of a group
	sequence s_chip_rise0;
		chip_arm_ff[0] && chip_trig_in[0] && !$past(chip_trig_in[0]);
	endsequence
	sequence s_lane_rise0;
		lane_arm_ff[0] && lane_trig_in[0] && !$past(lane_trig_in[0]);
	endsequence

	AST_UNARMED_ZERO: assert property (
		1'b1 |=> ((chip_flag & ~$past(chip_arm_ff)) == '0)
	) else $error("flag set on an unarmed per-chip event");

	AST_CHIP_RISE_SETS: assert property (
		s_chip_rise0 |=> chip_flag[0]
			##1 (chip_flag[0] || !$past(chip_arm_ff[0]) || $past(chip_clr[0]))
	) else $error("armed rising edge did not set and hold the flag");

	AST_LANE_RISE_SETS: assert property (
		s_lane_rise0 |=> lane_flag[0]
	) else $error("armed lane edge not latched");

	AST_ALERT_FOLLOWS: assert property (
		any_flag |=> !alert_oe_n_out && !alert_n_out
	) else $error("alert not driven low with a flag set");

	AST_ALERT_RELEASE: assert property (
		!any_flag |=> alert_oe_n_out
	) else $error("alert still driven with no flag");

	AST_CLEAR_WORKS: assert property (
		(wr_en_in && addr_in == `EIA_CHIP_STAT_ADDR && wr_data_in[0]
			&& !(chip_trig_in[0] && !$past(chip_trig_in[0]))) |=> !chip_flag[0]
	) else $error("clear write left the flag set");

	AST_CHIP_RAW_RDBK: assert property (
		(rd_en_in && addr_in == `EIA_CHIP_STAT_ADDR && !chip_arm_ff[1])
			|=> rd_valid_out && rd_data_out[1] == $past(chip_trig_in[1])
	) else $error("unarmed per-chip readback is not the raw trigger");

	AST_LANE_ZERO_RDBK: assert property (
		(rd_en_in && addr_in == `EIA_LANE_STAT0_ADDR && !lane_arm_ff[0])
			|=> rd_data_out[0] == 1'b0
	) else $error("unarmed lane readback not zero");

	AST_ARM_WRITE: assert property (
		(wr_en_in && addr_in == `EIA_CHIP_ARM_ADDR) |=> chip_arm_ff == $past(wr_data_in)
	) else $error("per-chip arm write not stored");

	AST_LINK_ARM_WRITE: assert property (
		(wr_en_in && addr_in == `EIA_LINK_ARM1_ADDR) |=> link_arm_ff[15:8] == $past(wr_data_in)
	) else $error("link arm write not stored");

	AST_LANE_ARM_WRITE: assert property (
		(wr_en_in && addr_in == `EIA_LANE_ARM1_ADDR) |=> lane_arm_ff[15:8] == $past(wr_data_in)
	) else $error("lane arm write not stored");
endmodule : eia_aggregator

// File: pkg/eia_consts.svh
/*
 Register offsets, field sizes and reset values of the event interrupt aggregator.
 Assumes inclusion by bare name from the design files; definitions only.
*/
`ifndef EIA_CONSTS_SVH
`define EIA_CONSTS_SVH

// ==========================================================================
// Address map (12-bit configuration address, 8-bit data)
`define EIA_ADDR_W          12
`define EIA_DATA_W          8
`define EIA_CHIP_ARM_ADDR   12'h020
`define EIA_CHIP_STAT_ADDR  12'h024
`define EIA_LINK_ARM0_ADDR  12'h470
`define EIA_LINK_ARM1_ADDR  12'h471
`define EIA_LINK_STAT0_ADDR 12'h472
`define EIA_LINK_STAT1_ADDR 12'h473
`define EIA_LANE_ARM0_ADDR  12'h4B8
`define EIA_LANE_ARM1_ADDR  12'h4B9
`define EIA_LANE_STAT0_ADDR 12'h4BA
`define EIA_LANE_STAT1_ADDR 12'h4BB

// ==========================================================================
// Event counts per group and reset values
`define EIA_CHIP_EVENTS     8
`define EIA_LINK_EVENTS     16
`define EIA_LANE_EVENTS     16
`define EIA_CHIP_ARM_RST    8'h00
`define EIA_GRP_ARM_RST     16'h0000
`define EIA_RD_DATA_RST     8'h00

`endif

// File: pkg/eia_pkg.sv
/*
 Types shared by the event interrupt aggregator.
 Assumes nothing of its surroundings.
*/
package eia_pkg;
	// ======================================================================
	// Bus word types
	typedef logic [11:0] eia_addr_t;
	typedef logic [7:0]  eia_data_t;
endpackage : eia_pkg

// File: rtl/eia_event_cell.sv
/*
 A row of event cells: edge detect, arm gating, sticky flag and readback mux.
 Assumes triggers are already in the clk_in domain.
*/
module eia_event_cell #(
	parameter int W = 8
) (
	input  wire logic         clk_in,
	input  wire logic         reset_n_in,
	input  wire logic [W-1:0] trig_in,
	input  wire logic [W-1:0] arm_in,
	input  wire logic [W-1:0] clr_in,
	input  wire logic [W-1:0] sel_flag_in,
	output logic      [W-1:0] flag_out,
	output logic      [W-1:0] rdbk_out
);
	logic [W-1:0] trig_prev_ff;
	logic [W-1:0] flag_ff;
	logic [W-1:0] rise;

	// ======================================================================
	// Edge detect against last cycle's trigger
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			trig_prev_ff <= '0;
		end else begin
			trig_prev_ff <= trig_in;
		end
	end
	assign rise = trig_in & ~trig_prev_ff;

	// Sticky flag; a set in the clear cycle wins so no event is lost
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			flag_ff <= '0;
		end else begin
			flag_ff <= arm_in & ((flag_ff & ~clr_in) | rise);
		end
	end

	assign flag_out = flag_ff;
	// Readback picks latched flag or raw trigger; the flag path is gated by the arm bit
	// so a read in the cycle right after a disarm never shows the stale flag
	assign rdbk_out = (sel_flag_in & arm_in & flag_ff) | (~sel_flag_in & trig_in);
endmodule : eia_event_cell

// File: bench/eia_host_model.sv
/*
 Host processor model driving the aggregator's register strobe port.
 Assumes the bench calls its tasks and wires its outputs to the design.
*/
module eia_host_model (
	input  wire logic               clk_in,
	input  wire eia_pkg::eia_data_t rd_data_in,
	input  wire logic               rd_valid_in,
	output logic                    wr_en_out,
	output logic                    rd_en_out,
	output eia_pkg::eia_addr_t      addr_out,
	output eia_pkg::eia_data_t      wr_data_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// ======================================================================
	// Idle state; address inverts after every access and data after every write, so stale values never match
	initial begin
		wr_en_out = 1'b0;
		rd_en_out = 1'b0;
		addr_out = 12'h000;
		wr_data_out = 8'h00;
	end
	task automatic wr(input eia_pkg::eia_addr_t a, input eia_pkg::eia_data_t d);
		@(negedge clk_in);
		addr_out = a;
		wr_data_out = d;
		wr_en_out = 1'b1;
		@(negedge clk_in);
		wr_en_out = 1'b0;
		addr_out = ~a;
		wr_data_out = ~d;
	endtask : wr
	task automatic rd(input eia_pkg::eia_addr_t a, output eia_pkg::eia_data_t d, output logic v);
		@(negedge clk_in);
		addr_out = a;
		rd_en_out = 1'b1;
		@(negedge clk_in);
		rd_en_out = 1'b0;
		addr_out = ~a;
		d = rd_data_in;
		v = rd_valid_in;
	endtask : rd
	// Alert service: status, disarm, inspect source, clear, then re-arm
	task automatic service(input eia_pkg::eia_addr_t arm_a, input eia_pkg::eia_addr_t st_a,
		input eia_pkg::eia_data_t bits, output eia_pkg::eia_data_t st,
		output eia_pkg::eia_data_t src);
		logic v;
		rd(st_a, st, v);
		wr(arm_a, 8'h00);
		rd(st_a, src, v);
		wr(st_a, bits);
		wr(arm_a, bits);
	endtask : service
endmodule : eia_host_model

// File: bench/eia_aggregator_tb_top.sv
/*
 Self-checking bench of the event interrupt aggregator with a host model.
 Assumes the design package and header are compiled first.
*/
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin num_errors++; \
	$display("BAD %0t got %h expected %h", $time, got, exp); end end
module eia_aggregator_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic               clk_in, reset_n_in, wr_en, rd_en, rd_valid, alert_n, alert_oe_n;
	logic               alert_wire;
	eia_pkg::eia_addr_t addr;
	eia_pkg::eia_data_t wr_data, rd_data, st, src;
	logic [7:0]         chip_trig;
	logic [15:0]        link_trig, lane_trig;
	int                 num_errors = 0;
	int                 checks = 0;
	// ======================================================================
	// Pull-up on the shared alert wire
	assign alert_wire = alert_oe_n ? 1'b1 : alert_n;
	eia_aggregator u_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .wr_en_in(wr_en),
		.rd_en_in(rd_en), .addr_in(addr), .wr_data_in(wr_data), .chip_trig_in(chip_trig),
		.link_trig_in(link_trig), .lane_trig_in(lane_trig), .rd_data_out(rd_data),
		.rd_valid_out(rd_valid), .alert_n_out(alert_n), .alert_oe_n_out(alert_oe_n));
	eia_host_model u_host (.clk_in(clk_in), .rd_data_in(rd_data), .rd_valid_in(rd_valid),
		.wr_en_out(wr_en), .rd_en_out(rd_en), .addr_out(addr), .wr_data_out(wr_data));
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	task automatic rd_chk(input eia_pkg::eia_addr_t a, input eia_pkg::eia_data_t exp);
		eia_pkg::eia_data_t d;
		logic v;
		u_host.rd(a, d, v);
		`CHK(v, 1'b1)
		`CHK(d, exp)
	endtask : rd_chk
	task automatic print_verdict();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : print_verdict
	// Reset values and an unmapped address
	task automatic test_reset();
		rd_chk(12'h020, 8'h00);
		rd_chk(12'h100, 8'h00);
		`CHK(alert_wire, 1'b1)
		$display("test_reset done");
	endtask : test_reset
	// Per-chip group: sticky flag, raw readback, full service routine
	task automatic test_chip();
		u_host.wr(12'h020, 8'h03);
		chip_trig = 8'h05;
		repeat (2) @(negedge clk_in);
		`CHK(alert_wire, 1'b0)
		rd_chk(12'h024, 8'h05);
		chip_trig = 8'h04;
		rd_chk(12'h024, 8'h05);
		chip_trig = 8'h00;
		u_host.service(12'h020, 12'h024, 8'h01, st, src);
		`CHK(st, 8'h01)
		`CHK(src, 8'h00)
		`CHK(alert_wire, 1'b1)
		chip_trig = 8'h02;
		repeat (3) @(negedge clk_in);
		`CHK(alert_wire, 1'b1)
		chip_trig = 8'h00;
		rd_chk(12'h020, 8'h01);
		$display("test_chip done");
	endtask : test_chip
	// Link or lane group: low byte armed, high byte not; trigger held across the clear
	task automatic test_group(input eia_pkg::eia_addr_t arm_a, input eia_pkg::eia_addr_t st_a,
		input bit lane);
		u_host.wr(arm_a, 8'hFF);
		if (lane) lane_trig = 16'h0201;
		else link_trig = 16'h0201;
		repeat (2) @(negedge clk_in);
		`CHK(alert_wire, 1'b0)
		rd_chk(st_a, 8'h01);
		rd_chk(st_a + 12'h001, 8'h00);
		u_host.wr(st_a, 8'h01);
		rd_chk(st_a, 8'h00);
		`CHK(alert_wire, 1'b1)
		rd_chk(arm_a, 8'h00);
		// High byte: arm, set, read and clear through the second address
		link_trig = 16'h0000;
		lane_trig = 16'h0000;
		u_host.wr(arm_a + 12'h001, 8'h02);
		if (lane) lane_trig = 16'h0200;
		else link_trig = 16'h0200;
		repeat (2) @(negedge clk_in);
		`CHK(alert_wire, 1'b0)
		rd_chk(st_a + 12'h001, 8'h02);
		u_host.wr(st_a + 12'h001, 8'h02);
		rd_chk(st_a + 12'h001, 8'h00);
		`CHK(alert_wire, 1'b1)
		// Disarming a set flag drops it and its readback
		if (lane) lane_trig = 16'h0001;
		else link_trig = 16'h0001;
		u_host.wr(arm_a, 8'h00);
		rd_chk(st_a, 8'h00);
		`CHK(alert_wire, 1'b1)
		u_host.wr(arm_a + 12'h001, 8'h00);
		link_trig = 16'h0000;
		lane_trig = 16'h0000;
		$display("test_group done");
	endtask : test_group
	// Device reset in mid-run drops a pending flag
	task automatic test_reset_mid();
		u_host.wr(12'h020, 8'h01);
		chip_trig = 8'h01;
		repeat (2) @(negedge clk_in);
		`CHK(alert_wire, 1'b0)
		reset_n_in = 1'b0;
		chip_trig = 8'h00;
		@(negedge clk_in);
		`CHK(alert_oe_n, 1'b1)
		reset_n_in = 1'b1;
		rd_chk(12'h024, 8'h00);
		rd_chk(12'h020, 8'h00);
		$display("test_reset_mid done");
	endtask : test_reset_mid
	// Watchdog well beyond the hundred or so cycles the tests need
	initial begin
		repeat (5000) @(posedge clk_in);
		num_errors++;
		print_verdict();
	end
	initial begin
		reset_n_in = 1'b0;
		chip_trig = 8'h00;
		link_trig = 16'h0000;
		lane_trig = 16'h0000;
		repeat (8) @(negedge clk_in);
		reset_n_in = 1'b1;
		test_reset();
		test_chip();
		test_group(12'h470, 12'h472, 1'b0);
		test_group(12'h4B8, 12'h4BA, 1'b1);
		test_reset_mid();
		print_verdict();
	end
endmodule : eia_aggregator_tb_top
